// File: adc_result_format_irq.sv
// Converter back end: completion flag, interrupts, wake and result registers
//
// Operation
// - Set done flag on every conversion finish; here a finish in sleep without the RC clock is dropped
// - Request interrupt when done flag and enable
// - Done flag cleared only by software writing zero
// - Convert in sleep only with RC clock
// - Enabled completion interrupt wakes a sleeping device
// - After wake, execute instruction after sleep first
// - Both interrupt enables set: branch to service routine
// - Ten and twelve bit results, two formats
// - Format select 0 sign-magnitude, 1 two's complement
// - Sign-magnitude left-justified, sign at bit zero
// - Sign bit one means negative result
// - Two's complement right-justified, sign extended upward
//
// Chosen here: strobed register access and the register offsets.
module adc_result_format_irq
(
    input  wire logic                   ref_clk,      // System clock
    input  wire logic                   rst,          // Async reset, active high
    input  wire logic [adc_pkg::ADDR_W-1:0] addr,     // Register address
    input  wire logic [adc_pkg::DATA_W-1:0] wdata,    // Write data
    input  wire logic                   wr,           // Write strobe
    input  wire logic                   rd,           // Read strobe
    output logic [adc_pkg::DATA_W-1:0]  rdata,        // Read data, cycle after rd
    input  wire logic                   conv_done,    // Conversion finished pulse
    input  wire logic [adc_pkg::RAW_W-1:0] conv_mag,  // Conversion magnitude
    input  wire logic                   conv_neg,     // Conversion sign
    input  wire logic                   sleep_enter,  // Core executed sleep pulse
    output logic                        conv_run_en,  // Analog may convert
    output logic                        asleep,       // Device is in sleep
    output logic                        done_irq_req, // Completion interrupt request
    output logic                        wake,         // Wake pulse to core
    output logic                        wake_isr,     // Wake then vector to handler
    output logic                        wake_inline,  // Wake then continue in line
    output logic                        irq           // Masked event interrupt
);
    import adc_pkg::*;

    // ------------------------------------------------------------
    // Types and state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        PWR_RUN   = 1'b0,
        PWR_SLEEP = 1'b1
    } pwr_e;

    pwr_e pwr_r;
    pwr_e pwr_nxt;

    logic [DATA_W-1:0] flag1_r;
    logic [DATA_W-1:0] ena1_r;
    logic [DATA_W-1:0] irqctl_r;
    logic [DATA_W-1:0] ctl0_r;
    logic [DATA_W-1:0] ctl1_r;
    logic [EVT_W-1:0]  evt_st_r;
    logic [EVT_W-1:0]  evt_mk_r;
    logic [DATA_W-1:0] rdata_r;
    logic              run_en_r;
    logic              req_r;
    logic              wake_r;
    logic              wake_isr_r;
    logic              wake_inl_r;
    logic              irq_r;

    fmt_if fp ();

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // One decode shared by every register write
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0]        off);
        hit = (a == off);
    endfunction : hit

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr_flag1  = wr && hit(addr, OFF_FLAG1);
    wire wr_ena1   = wr && hit(addr, OFF_ENA1);
    wire wr_irqctl = wr && hit(addr, OFF_IRQCTL);
    wire wr_ctl0   = wr && hit(addr, OFF_CTL0);
    wire wr_ctl1   = wr && hit(addr, OFF_CTL1);
    wire wr_evt_st = wr && hit(addr, OFF_EVT_ST);
    wire wr_evt_mk = wr && hit(addr, OFF_EVT_MK);

    // ------------------------------------------------------------
    // Conversion acceptance
    // ------------------------------------------------------------
    wire rc_clk_sel = (ctl1_r[CLKSEL_MSB:CLKSEL_LSB] == CLKSEL_RC);
    // Any clock but the RC source stops in sleep, so a late pulse is dropped
    wire may_run    = (pwr_r == PWR_RUN) || rc_clk_sel;
    wire done_acc   = conv_done && may_run;

    // Result packer inputs
    assign fp.raw       = conv_mag;
    assign fp.neg       = conv_neg;
    assign fp.fmt_sel   = ctl1_r[BIT_FMT_SEL];
    assign fp.width_sel = ctl0_r[BIT_WIDTH_SEL];
    assign fp.load      = done_acc;

    result_packer u_pack (
        .ref_clk (ref_clk),
        .rst     (rst),
        .fp      (fp)
    );

    // ------------------------------------------------------------
    // Completion flag
    // ------------------------------------------------------------
    // Set regardless of enable; only a written zero clears it, set wins
    wire done_flag = flag1_r[BIT_DONE_FLAG];
    wire flag_clr  = wr_flag1 && !wdata[BIT_DONE_FLAG];
    wire flag_nxt  = done_acc || (done_flag && !flag_clr);

    // Other bits of the flag register belong to other peripherals
    wire [DATA_W-1:0] flag1_nxt = {1'b0, flag_nxt, 6'h00};

    // ------------------------------------------------------------
    // Interrupt and wake decisions
    // ------------------------------------------------------------
    wire done_ie    = ena1_r[BIT_DONE_IE];
    wire req_nxt    = flag_nxt && done_ie;
    wire both_ie    = irqctl_r[BIT_GLOBAL_IE] && irqctl_r[BIT_PERIPH_IE];
    // Wake is taken from the live flag so a flag set before sleep still wakes
    wire wake_now   = (pwr_r == PWR_SLEEP) && done_flag && done_ie;

    // Sleep entry and wake
    always_comb begin
        pwr_nxt = pwr_r;
        unique case (pwr_r)
            PWR_RUN: begin
                if (sleep_enter) begin
                    pwr_nxt = PWR_SLEEP;
                end
            end
            PWR_SLEEP: begin
                if (wake_now) begin
                    pwr_nxt = PWR_RUN;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Event status, mask and interrupt line
    // ------------------------------------------------------------
    wire [EVT_W-1:0] evt_set = {wake_now, done_acc};
    wire [EVT_W-1:0] evt_clr = wr_evt_st ? wdata[EVT_W-1:0] : RST_EVT;
    // Write one to clear, but a same-cycle event survives
    wire [EVT_W-1:0] evt_nxt = evt_set | (evt_st_r & ~evt_clr);
    wire             irq_nxt = |(evt_nxt & evt_mk_r);

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        rd_mux = RST_BYTE;
        unique case (addr)
            OFF_FLAG1:  rd_mux = flag1_r;
            OFF_ENA1:   rd_mux = ena1_r;
            OFF_IRQCTL: rd_mux = irqctl_r;
            OFF_CTL0:   rd_mux = ctl0_r;
            OFF_CTL1:   rd_mux = ctl1_r;
            OFF_RES_LO: rd_mux = fp.result[7:0];
            OFF_RES_HI: rd_mux = fp.result[15:8];
            OFF_EVT_ST: rd_mux = {6'h00, evt_st_r};
            OFF_EVT_MK: rd_mux = {6'h00, evt_mk_r};
            default:    rd_mux = RST_BYTE;
        endcase
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Completion enable; other bits are stored so software reads them back
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ena1_r <= RST_BYTE;
        end else if (wr_ena1) begin
            ena1_r <= wdata;
        end
    end

    // Global and peripheral enables; either one cleared gives an in-line resume
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqctl_r <= RST_BYTE;
        end else if (wr_irqctl) begin
            irqctl_r <= wdata;
        end
    end

    // Width select lives in control 0
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl0_r <= RST_BYTE;
        end else if (wr_ctl0) begin
            ctl0_r <= wdata;
        end
    end

    // Format and clock select; a new clock choice governs the next pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctl1_r <= RST_BYTE;
        end else if (wr_ctl1) begin
            ctl1_r <= wdata;
        end
    end

    // Only the implemented event bits are kept in the mask
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evt_mk_r <= RST_EVT;
        end else if (wr_evt_mk) begin
            evt_mk_r <= wdata[EVT_W-1:0];
        end
    end

    // Completion flag; hardware sets, only software clears
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag1_r <= RST_BYTE;
        end else begin
            flag1_r <= flag1_nxt;
        end
    end

    // Event status, write one to clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            evt_st_r <= RST_EVT;
        end else begin
            evt_st_r <= evt_nxt;
        end
    end

    // Power state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pwr_r <= PWR_RUN;
        end else begin
            pwr_r <= pwr_nxt;
        end
    end

    // Zero outside the read cycle, so several slaves may share one bus
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= RST_BYTE;
        end else begin
            rdata_r <= rd ? rd_mux : RST_BYTE;
        end
    end

    // Converter stays alive in sleep only on its own RC clock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_en_r <= 1'b1;
        end else begin
            run_en_r <= (pwr_nxt == PWR_RUN) || rc_clk_sel;
        end
    end

    // Completion request level toward the interrupt logic
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
        end
    end

    // Wake and its two flavours, exclusive because both_ie is one bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_r     <= 1'b0;
            wake_isr_r <= 1'b0;
            wake_inl_r <= 1'b0;
        end else begin
            wake_r     <= wake_now;
            wake_isr_r <= wake_now && both_ie;
            wake_inl_r <= wake_now && !both_ie;
        end
    end

    // Masked event interrupt line
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Output drive
    // ------------------------------------------------------------
    assign rdata        = rdata_r;
    assign conv_run_en  = run_en_r;
    assign asleep       = pwr_r;
    assign done_irq_req = req_r;
    assign wake         = wake_r;
    assign wake_isr     = wake_isr_r;
    assign wake_inline  = wake_inl_r;
    assign irq          = irq_r;

endmodule : adc_result_format_irq

// File: adc_pkg.sv
// Shared constants for the converter result and interrupt back end
package adc_pkg;

    // ------------------------------------------------------------
    // Bus and result widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int RAW_W  = 12;
    localparam int RES_W  = 16;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_FLAG1  = 4'h0;
    localparam logic [3:0] OFF_ENA1   = 4'h1;
    localparam logic [3:0] OFF_IRQCTL = 4'h2;
    localparam logic [3:0] OFF_CTL0   = 4'h3;
    localparam logic [3:0] OFF_CTL1   = 4'h4;
    localparam logic [3:0] OFF_RES_LO = 4'h5;
    localparam logic [3:0] OFF_RES_HI = 4'h6;
    localparam logic [3:0] OFF_EVT_ST = 4'h7;
    localparam logic [3:0] OFF_EVT_MK = 4'h8;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DONE_FLAG = 6;
    localparam int BIT_DONE_IE   = 6;
    localparam int BIT_GLOBAL_IE = 7;
    localparam int BIT_PERIPH_IE = 6;
    localparam int BIT_WIDTH_SEL = 7;
    localparam int BIT_FMT_SEL   = 7;
    localparam int CLKSEL_LSB    = 4;
    localparam int CLKSEL_MSB    = 6;
    localparam int EVT_DONE      = 0;
    localparam int EVT_WAKE      = 1;
    localparam int EVT_W         = 2;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [2:0]        CLKSEL_RC   = 3'h7;
    localparam logic [7:0]        RST_BYTE    = 8'h00;
    localparam logic [EVT_W-1:0]  RST_EVT     = 2'h0;
    localparam logic [RES_W-1:0]  RST_RESULT  = 16'h0000;

endpackage : adc_pkg

// File: fmt_if.sv
// Link between the control block and the result packer
interface fmt_if;
    import adc_pkg::*;

    logic [RAW_W-1:0] raw;       // Conversion magnitude
    logic             neg;       // Result is negative
    logic             fmt_sel;   // 0 sign-magnitude, 1 two's complement
    logic             width_sel; // 0 twelve bits, 1 ten bits
    logic             load;      // Capture a new result
    logic [RES_W-1:0] result;    // Packed result pair

    modport ctrl (output raw, output neg, output fmt_sel, output width_sel,
                  output load, input result);
    modport pack (input raw, input neg, input fmt_sel, input width_sel,
                  input load, output result);
endinterface : fmt_if

// File: result_packer.sv
// Packs a magnitude and sign into the 16-bit result pair
module result_packer
    import adc_pkg::*;
(
    input  wire logic ref_clk, // System clock
    input  wire logic rst,     // Async reset, active high
    fmt_if.pack       fp       // Packing request and result
);

    // ------------------------------------------------------------
    // Format arithmetic
    // ------------------------------------------------------------
    // Magnitude for the chosen width; ten-bit results use the low bits
    wire [11:0] mag12 = fp.raw;
    wire [9:0]  mag10 = fp.raw[9:0];
    // Signed values one bit wider than the magnitude so full scale fits
    wire [12:0] tc12  = fp.neg ? 13'(~{1'b0, mag12} + 13'h0001) : {1'b0, mag12};
    wire [10:0] tc10  = fp.neg ? 11'(~{1'b0, mag10} + 11'h001) : {1'b0, mag10};

    // Left-justified magnitude, zero fill, sign in bit 0
    wire [RES_W-1:0] sm12 = {mag12, 3'h0, fp.neg};
    wire [RES_W-1:0] sm10 = {mag10, 5'h00, fp.neg};
    // Right-justified, sign copied into unused upper bits
    wire [RES_W-1:0] tx12 = {{3{tc12[12]}}, tc12};
    wire [RES_W-1:0] tx10 = {{5{tc10[10]}}, tc10};

    wire [RES_W-1:0] sm_sel  = fp.width_sel ? sm10 : sm12;
    wire [RES_W-1:0] tc_sel  = fp.width_sel ? tx10 : tx12;
    wire [RES_W-1:0] packed_v = fp.fmt_sel ? tc_sel : sm_sel;

    // ------------------------------------------------------------
    // Result register
    // ------------------------------------------------------------
    // Both bytes change in one edge, so a pair is torn only by a load between the two byte reads
    logic [RES_W-1:0] result_r;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_r <= RST_RESULT;
        end else if (fp.load) begin
            result_r <= packed_v;
        end
    end

    assign fp.result = result_r;

endmodule : result_packer

// File: adc_result_format_irq_props.sv
// Port-level checks for the converter back end
module adc_result_format_irq_chk
(
    input  wire logic                      ref_clk,      // System clock
    input  wire logic                      rst,          // Async reset
    input  wire logic                      wr,           // Write strobe
    input  wire logic                      rd,           // Read strobe
    input  wire logic [adc_pkg::DATA_W-1:0] rdata,       // Read data
    input  wire logic                      sleep_enter,  // Sleep pulse
    input  wire logic                      conv_done,    // Conversion end
    input  wire logic                      conv_run_en,  // Analog may convert
    input  wire logic                      asleep,       // Sleep state
    input  wire logic                      done_irq_req, // Completion request
    input  wire logic                      wake,         // Wake pulse
    input  wire logic                      wake_isr,     // Wake to handler
    input  wire logic                      wake_inline,  // Wake in line
    input  wire logic                      irq           // Event interrupt
);
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // One domain, so clock and reset are given once
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    chk_req_cause: assert property ($rose(done_irq_req) |-> $past(wr, 2) || $past(conv_done))
        else $error("completion request rose without cause");
    chk_req_sticky: assert property ($fell(done_irq_req) |-> $past(wr) || $past(wr, 2))
        else $error("completion request dropped without write");
    chk_irq_sticky: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
        else $error("interrupt dropped without write");
    chk_sleep_entry: assert property (sleep_enter && !asleep |=> asleep)
        else $error("sleep not entered");
    chk_run_awake: assert property (!asleep |-> conv_run_en)
        else $error("converter stopped while awake");
    chk_wake_cause: assert property (wake |-> $past(asleep) && !asleep && $past(done_irq_req))
        else $error("wake without pending request in sleep");
    chk_wake_kind: assert property (wake |-> (wake_isr ^ wake_inline))
        else $error("wake kind not exactly one");
    chk_kind_wake: assert property ((wake_isr || wake_inline) |-> wake ##1 !wake)
        else $error("wake kind without single wake pulse");
endmodule : adc_result_format_irq_chk

bind adc_result_format_irq adc_result_format_irq_chk u_chk (.ref_clk(ref_clk), .rst(rst),
    .wr(wr), .rd(rd), .rdata(rdata), .sleep_enter(sleep_enter), .conv_done(conv_done),
    .conv_run_en(conv_run_en), .asleep(asleep), .done_irq_req(done_irq_req), .wake(wake),
    .wake_isr(wake_isr), .wake_inline(wake_inline), .irq(irq));

// File: core_model.sv
// Processor core stand-in: issues sleep and notes how it resumed
module core_model
(
    input  wire logic       ref_clk,     // System clock
    input  wire logic       rst,         // Async reset
    input  wire logic       sleep_req,   // Bench asks core to sleep
    input  wire logic       wake,        // Wake pulse
    input  wire logic       wake_isr,    // Resume in handler
    input  wire logic       wake_inline, // Resume in line
    output logic            sleep_enter, // Sleep executed pulse
    output logic [1:0]      resume_r     // 0 none, 1 in line, 2 handler
);
    timeunit 1ns;
    timeprecision 100ps;

    // Sleep instruction retires one cycle after the request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sleep_enter <= 1'b0;
            resume_r    <= 2'h0;
        end else begin
            sleep_enter <= sleep_req;
            if (sleep_req) resume_r <= 2'h0;
            else if (wake && wake_inline) resume_r <= 2'h1;
            else if (wake && wake_isr) resume_r <= 2'h2;
        end
    end
endmodule : core_model

// File: adc_result_format_irq_tb.sv
// Self-checking bench for the converter back end
module adc_result_format_irq_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import adc_pkg::*;

    logic              ref_clk, rst, wr, rd, conv_done, conv_neg, sleep_req;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, lo, hi;
    logic [RAW_W-1:0]  conv_mag;
    logic              conv_run_en, asleep, done_irq_req, wake, wake_isr, wake_inline;
    logic              irq, sleep_enter;
    logic [1:0]        resume_r;
    int                res_q[$];   // Expected result pairs, newest last
    int                n_errors, n_tests, seed;

    adc_result_format_irq uut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .conv_done(conv_done), .conv_mag(conv_mag),
        .conv_neg(conv_neg), .sleep_enter(sleep_enter), .conv_run_en(conv_run_en),
        .asleep(asleep), .done_irq_req(done_irq_req), .wake(wake), .wake_isr(wake_isr),
        .wake_inline(wake_inline), .irq(irq));
    core_model core (.ref_clk(ref_clk), .rst(rst), .sleep_req(sleep_req), .wake(wake),
        .wake_isr(wake_isr), .wake_inline(wake_inline), .sleep_enter(sleep_enter),
        .resume_r(resume_r));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Strobes drop for a cycle between accesses, so no double drive
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk); addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge ref_clk); wr <= 1'b0;
        @(negedge ref_clk);
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge ref_clk); addr <= a; rd <= 1'b1;
        @(posedge ref_clk); rd <= 1'b0;
        @(negedge ref_clk); v = rdata;
    endtask : rd_reg
    task conv(input logic [11:0] m, input logic n);
        @(posedge ref_clk); conv_done <= 1'b1; conv_mag <= m; conv_neg <= n;
        @(posedge ref_clk); conv_done <= 1'b0; conv_mag <= ~m; conv_neg <= ~n;
        @(negedge ref_clk);
    endtask : conv
    task nap;
        @(posedge ref_clk); sleep_req <= 1'b1;
        @(posedge ref_clk); sleep_req <= 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask : nap
    // Bounded wait for the core to report a resume
    task wait_wake;
        for (int i = 0; i < 10 && resume_r == 2'h0; i++) @(negedge ref_clk);
    endtask : wait_wake
    // Expected result pair from magnitude, sign, format and width
    function automatic logic [15:0] exp_res(int m, int n, int f, int w);
        int v;
        v = w ? (m & 32'h3FF) : (m & 32'hFFF);
        if (f == 0) return w ? 16'((v << 6) | n) : 16'((v << 4) | n);
        return n ? 16'(-v) : 16'(v);
    endfunction : exp_res
    task end_sim;
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        end_sim();
    end
    initial begin
        {rst, wr, rd, conv_done, conv_neg, sleep_req} = 6'b100000;
        addr = '0; wdata = '0; conv_mag = '0; n_errors = 0; n_tests = 0;
        seed = 32'h790F8039;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values, unmapped space ignores writes
        wr_reg(4'hC, 8'hFF);
        for (int a = 0; a < 16; a++) begin
            rd_reg(a[3:0], lo); chk({8'h00, lo}, 16'h0000);
        end
        $display("test reset done");
        // Every format and width with random results
        wr_reg(OFF_ENA1, 8'h40); wr_reg(OFF_EVT_MK, 8'h01);
        for (int k = 0; k < 16; k++) begin
            wr_reg(OFF_CTL0, {k[1], 7'h00}); wr_reg(OFF_CTL1, {k[0], 7'h00});
            conv(12'($random(seed)), 1'($random(seed)));
            res_q.push_back(exp_res(int'(conv_mag ^ 12'hFFF), int'(!conv_neg), k & 1,
                                    (k >> 1) & 1));
            rd_reg(OFF_RES_LO, lo); rd_reg(OFF_RES_HI, hi);
            chk({hi, lo}, 16'(res_q[$]));
            chk({14'h0, done_irq_req, irq}, 16'h0003);
            wr_reg(OFF_FLAG1, 8'hFF); rd_reg(OFF_FLAG1, lo);
            chk({8'h00, lo}, 16'h0040);
            wr_reg(OFF_FLAG1, 8'h00); wr_reg(OFF_EVT_ST, 8'h01);
            chk({14'h0, done_irq_req, irq}, 16'h0000);
        end
        $display("test formats done");
        // Sleep with a non-RC clock drops conversions, RC clock wakes in line
        wr_reg(OFF_IRQCTL, 8'h00); wr_reg(OFF_CTL1, 8'h00);
        nap();
        chk({14'h0, asleep, conv_run_en}, 16'h0002);
        conv(12'h5A5, 1'b1);
        rd_reg(OFF_RES_LO, lo); rd_reg(OFF_RES_HI, hi);
        chk({hi, lo}, 16'(res_q[$]));
        chk({15'h0, asleep}, 16'h0001);
        wr_reg(OFF_CTL1, {1'b0, CLKSEL_RC, 4'h0});
        conv(12'h3C3, 1'b0); wait_wake();
        chk({13'h0, asleep, resume_r}, 16'h0001);
        res_q.push_back(exp_res(12'h3C3, 0, 0, 1));
        rd_reg(OFF_RES_LO, lo); rd_reg(OFF_RES_HI, hi);
        chk({hi, lo}, 16'(res_q[$]));
        rd_reg(OFF_EVT_ST, lo); chk({8'h00, lo}, 16'h0003);
        // Both enables set: wake goes to the handler
        wr_reg(OFF_FLAG1, 8'h00); wr_reg(OFF_IRQCTL, 8'hC0);
        nap(); conv(12'h0F0, 1'b1); wait_wake();
        chk({13'h0, asleep, resume_r}, 16'h0002);
        res_q.push_back(exp_res(12'h0F0, 1, 0, 1));
        rd_reg(OFF_RES_LO, lo); rd_reg(OFF_RES_HI, hi);
        chk({hi, lo}, 16'(res_q[$]));
        $display("test sleep done");
        end_sim();
    end
endmodule : adc_result_format_irq_tb
